// >>> design/rdc_ctrl.v
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rdc_map.vh"
module rdc_ctrl #(
    parameter POLL_CYC = `RDC_POLL_CYC
) (
    MCLK,
    RST,
    BOOST_HIGH_DIGIT_GROUP_A,
    BOOST_LOW_DIGIT_GROUP_A,
    BOOST_HIGH_DIGIT_GROUP_B,
    BOOST_LOW_DIGIT_GROUP_B,
    FLAT_LEVEL_GROUP_A,
    FLAT_LEVEL_GROUP_B,
    POWERDOWN_GROUP_A,
    POWERDOWN_GROUP_B,
    DETECT_CONFIG_PIN,
    MUX_SELECT_GROUP_A,
    MUX_SELECT_GROUP_B,
    MODE_PIN,
    LOAD_START_N,
    FAR_TERM_A,
    FAR_TERM_B,
    BOOST_INDEX_A,
    BOOST_INDEX_B,
    FLAT_A,
    FLAT_B,
    CROSS_A,
    CROSS_B,
    TERM_50_A,
    TERM_50_B,
    PATH_RESET_A,
    PATH_RESET_B,
    DETECT_PULSE_A,
    DETECT_PULSE_B,
    STANDBY,
    LOAD_DONE_N,
    LOAD_ACTIVE,
    PSEL,
    PENABLE,
    PWRITE,
    PADDR,
    PWDATA,
    PRDATA,
    PREADY,
    PSLVERR
);
    input wire MCLK;
    input wire RST;
    input wire [1:0] BOOST_HIGH_DIGIT_GROUP_A;
    input wire [1:0] BOOST_LOW_DIGIT_GROUP_A;
    input wire [1:0] BOOST_HIGH_DIGIT_GROUP_B;
    input wire [1:0] BOOST_LOW_DIGIT_GROUP_B;
    input wire [1:0] FLAT_LEVEL_GROUP_A;
    input wire [1:0] FLAT_LEVEL_GROUP_B;
    input wire POWERDOWN_GROUP_A;
    input wire POWERDOWN_GROUP_B;
    input wire [1:0] DETECT_CONFIG_PIN;
    input wire MUX_SELECT_GROUP_A;
    input wire MUX_SELECT_GROUP_B;
    input wire [1:0] MODE_PIN;
    input wire LOAD_START_N;
    input wire FAR_TERM_A;
    input wire FAR_TERM_B;
    output reg [3:0] BOOST_INDEX_A;
    output reg [3:0] BOOST_INDEX_B;
    output reg [1:0] FLAT_A;
    output reg [1:0] FLAT_B;
    output reg CROSS_A;
    output reg CROSS_B;
    output reg TERM_50_A;
    output reg TERM_50_B;
    output reg PATH_RESET_A;
    output reg PATH_RESET_B;
    output reg DETECT_PULSE_A;
    output reg DETECT_PULSE_B;
    output reg STANDBY;
    output reg LOAD_DONE_N;
    output reg LOAD_ACTIVE;
    input wire PSEL;
    input wire PENABLE;
    input wire PWRITE;
    input wire [11:0] PADDR;
    input wire [31:0] PWDATA;
    output reg [31:0] PRDATA;
    output wire PREADY;
    output wire PSLVERR;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    localparam SW = 22;
    wire [SW-1:0] pin_raw = {BOOST_HIGH_DIGIT_GROUP_A, BOOST_LOW_DIGIT_GROUP_A,
        BOOST_HIGH_DIGIT_GROUP_B, BOOST_LOW_DIGIT_GROUP_B, FLAT_LEVEL_GROUP_A,
        FLAT_LEVEL_GROUP_B, POWERDOWN_GROUP_A, POWERDOWN_GROUP_B, DETECT_CONFIG_PIN,
        MUX_SELECT_GROUP_A, MUX_SELECT_GROUP_B, MODE_PIN, LOAD_START_N, FAR_TERM_A};
    reg [SW-1:0] s1_ff;
    reg [SW-1:0] s2_ff;
    reg term_b1_ff;
    reg term_b2_ff;
    // no reset here, so pin levels are already valid when reset lifts
    always @(posedge MCLK)
    begin
        s1_ff <= pin_raw;
        s2_ff <= s1_ff;
        term_b1_ff <= FAR_TERM_B;
        term_b2_ff <= term_b1_ff;
    end
    wire [1:0] eqh_a = s2_ff[21:20];
    wire [1:0] eql_a = s2_ff[19:18];
    wire [1:0] eqh_b = s2_ff[17:16];
    wire [1:0] eql_b = s2_ff[15:14];
    wire [1:0] flat_pin_a = s2_ff[13:12];
    wire [1:0] flat_pin_b = s2_ff[11:10];
    wire [1:0] pd = {s2_ff[8], s2_ff[9]};
    wire [1:0] det_cfg = s2_ff[7:6];
    wire [1:0] sel = {s2_ff[4], s2_ff[5]};
    wire [1:0] mode = s2_ff[3:2];
    wire load_start_n = s2_ff[1];
    wire [1:0] far_term = {term_b2_ff, s2_ff[0]};

    // ************************************************************
    // configuration mode and apb registers
    // ************************************************************
    wire pin_mode = (mode == `RDC_LVL_L0);
    wire master_mode = (mode == `RDC_LVL_L1);
    reg [3:0] reg_boost_a_ff;
    reg [3:0] reg_boost_b_ff;
    reg [1:0] reg_flat_a_ff;
    reg [1:0] reg_flat_b_ff;
    reg [1:0] wr_restart_ff;
    reg load_seen_ff;
    reg load_done_ff;
    wire wr_en = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    wire addr_ok = (PADDR == `RDC_OFF_CTRL) || (PADDR == `RDC_OFF_BOOST) ||
        (PADDR == `RDC_OFF_STAT) || (PADDR == `RDC_OFF_FLAT);
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            reg_boost_a_ff <= 4'h0;
            reg_boost_b_ff <= 4'h0;
            reg_flat_a_ff <= `RDC_LVL_L3;
            reg_flat_b_ff <= `RDC_LVL_L3;
            wr_restart_ff <= 2'h0;
            load_seen_ff <= 1'b0;
            load_done_ff <= 1'b0;
        end
        else
        begin
            wr_restart_ff <= 2'h0;
            // registers answer in every mode, also during the load
            if (wr_en && PADDR == `RDC_OFF_BOOST)
            begin
                reg_boost_a_ff <= PWDATA[3:0];
                reg_boost_b_ff <= PWDATA[7:4];
            end
            if (wr_en && PADDR == `RDC_OFF_FLAT)
            begin
                reg_flat_a_ff <= PWDATA[1:0];
                reg_flat_b_ff <= PWDATA[5:4];
            end
            if (wr_en && PADDR == `RDC_OFF_CTRL)
            begin
                wr_restart_ff <= {PWDATA[`RDC_CTRL_RESTART_B], PWDATA[`RDC_CTRL_RESTART_A]};
                if (load_seen_ff && PWDATA[`RDC_CTRL_LOAD_DONE])
                    load_done_ff <= 1'b1;
            end
            if (master_mode && !load_start_n && !load_seen_ff)
                load_seen_ff <= 1'b1;
        end
    end
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            LOAD_DONE_N <= 1'b1;
            LOAD_ACTIVE <= 1'b0;
        end
        else
        begin
            LOAD_ACTIVE <= load_seen_ff && !load_done_ff;
            LOAD_DONE_N <= !(load_done_ff && master_mode);
        end
    end

    // ************************************************************
    // per group setting, routing and detect machine
    // ************************************************************
    localparam ST_OFF = 4'h1;
    localparam ST_HIZ = 4'h2;
    localparam ST_WAIT = 4'h4;
    localparam ST_LINK = 4'h8;
    wire det_on = (det_cfg != `RDC_LVL_L0);
    reg first_ff;
    reg [1:0] sel_d_ff;
    reg [1:0] pd_d_ff;
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            first_ff <= 1'b1;
            sel_d_ff <= 2'h0;
            pd_d_ff <= 2'h0;
        end
        else
        begin
            first_ff <= 1'b0;
            sel_d_ff <= sel;
            pd_d_ff <= pd;
        end
    end
    wire sel_chg = (sel != sel_d_ff) && !first_ff;
    wire [7:0] st_all;
    wire [1:0] hiz_q;
    wire [1:0] term_q;
    wire [1:0] rst_q;
    wire [1:0] pulse_q;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : grp
            wire pd_fall = pd_d_ff[g] && !pd[g] && pin_mode;
            wire restart = first_ff || pd_fall || wr_restart_ff[g] || sel_chg;
            reg [3:0] st_ff;
            reg [14:0] poll_ff;
            reg [3:0] nxt_st;
            always @*
            begin
                nxt_st = st_ff;
                case (st_ff)
                    ST_OFF: nxt_st = det_on ? ST_HIZ : ST_OFF;
                    ST_HIZ: nxt_st = ST_WAIT;
                    ST_WAIT:
                    begin
                        if (far_term[g])
                            nxt_st = ST_LINK;
                        else if (poll_ff == 15'h0000)
                            nxt_st = ST_HIZ;
                    end
                    ST_LINK: nxt_st = ST_LINK;
                    default: nxt_st = ST_OFF;
                endcase
                if (pd[g])
                    nxt_st = ST_HIZ;
                else if (!det_on)
                    nxt_st = ST_OFF;
                else if (restart)
                    nxt_st = ST_HIZ;
            end
            always @(posedge MCLK)
            begin
                if (RST)
                begin
                    st_ff <= ST_OFF;
                    poll_ff <= 15'h0000;
                end
                else
                begin
                    st_ff <= nxt_st;
                    if (nxt_st == ST_HIZ)
                        poll_ff <= POLL_CYC[14:0] - 15'h0001;
                    else if (poll_ff != 15'h0000)
                        poll_ff <= poll_ff - 15'h0001;
                end
            end
            assign st_all[4*g+3:4*g] = st_ff;
            // off state gives 50 ohm only while detection is disabled
            assign term_q[g] = ((st_ff == ST_OFF) && !det_on) || (st_ff == ST_LINK);
            assign rst_q[g] = pd[g];
            // one attempt strobe per entry into the wait state
            assign pulse_q[g] = (st_ff == ST_HIZ) && (nxt_st == ST_WAIT);
            assign hiz_q[g] = pd[g];
        end
    endgenerate

    // ************************************************************
    // output registers
    // ************************************************************
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            BOOST_INDEX_A <= 4'h0;
            BOOST_INDEX_B <= 4'h0;
            FLAT_A <= `RDC_LVL_L3;
            FLAT_B <= `RDC_LVL_L3;
            CROSS_A <= 1'b0;
            CROSS_B <= 1'b0;
            TERM_50_A <= 1'b0;
            TERM_50_B <= 1'b0;
            PATH_RESET_A <= 1'b1;
            PATH_RESET_B <= 1'b1;
            DETECT_PULSE_A <= 1'b0;
            DETECT_PULSE_B <= 1'b0;
            STANDBY <= 1'b0;
            PRDATA <= 32'h00000000;
        end
        else
        begin
            if (pin_mode)
            begin
                BOOST_INDEX_A <= {eqh_a, eql_a};
                BOOST_INDEX_B <= {eqh_b, eql_b};
                FLAT_A <= flat_pin_a;
                FLAT_B <= flat_pin_b;
            end
            else
            begin
                BOOST_INDEX_A <= reg_boost_a_ff;
                BOOST_INDEX_B <= reg_boost_b_ff;
                FLAT_A <= reg_flat_a_ff;
                FLAT_B <= reg_flat_b_ff;
            end
            CROSS_A <= sel[0];
            CROSS_B <= sel[1];
            TERM_50_A <= term_q[0] && !hiz_q[0];
            TERM_50_B <= term_q[1] && !hiz_q[1];
            PATH_RESET_A <= rst_q[0];
            PATH_RESET_B <= rst_q[1];
            DETECT_PULSE_A <= pulse_q[0];
            DETECT_PULSE_B <= pulse_q[1];
            STANDBY <= pd[0] && pd[1];
            PRDATA <= 32'h00000000;
            if (PSEL && !PWRITE)
            begin
                case (PADDR)
                    `RDC_OFF_BOOST: PRDATA <= {24'h000000, reg_boost_b_ff, reg_boost_a_ff};
                    `RDC_OFF_FLAT: PRDATA <= {26'h0000000, reg_flat_b_ff, 2'h0, reg_flat_a_ff};
                    `RDC_OFF_STAT: PRDATA <= {16'h0000, st_all, 2'h0, mode,
                        1'b0, load_done_ff, load_seen_ff, det_on};
                    default: PRDATA <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // rdc_ctrl

// >>> design/rdc_map.vh
`ifndef RDC_MAP_VH
`define RDC_MAP_VH
`define RDC_LVL_L0 2'h0
`define RDC_LVL_L1 2'h1
`define RDC_LVL_L2 2'h2
`define RDC_LVL_L3 2'h3
`define RDC_CLK_MHZ 100
`define RDC_POLL_US 150
`define RDC_POLL_CYC (`RDC_POLL_US * `RDC_CLK_MHZ)
`define RDC_OFF_CTRL 12'h000
`define RDC_OFF_BOOST 12'h004
`define RDC_OFF_STAT 12'h008
`define RDC_OFF_FLAT 12'h00c
`define RDC_CTRL_RESTART_A 0
`define RDC_CTRL_RESTART_B 1
`define RDC_CTRL_LOAD_DONE 2
`endif

// >>> verif/rdc_ctrl_sva.sv
`timescale 1ns/1ps
module rdc_ctrl_sva #(
    parameter POLL_CYC = 20
) (
    input wire MCLK,
    input wire RST,
    input wire POWERDOWN_GROUP_A,
    input wire POWERDOWN_GROUP_B,
    input wire [1:0] DETECT_CONFIG_PIN,
    input wire MUX_SELECT_GROUP_A,
    input wire CROSS_A,
    input wire TERM_50_A,
    input wire TERM_50_B,
    input wire PATH_RESET_A,
    input wire DETECT_PULSE_A,
    input wire STANDBY,
    input wire LOAD_DONE_N
);
    // ********
    // checks
    // ********
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    chk_pd_a_hiz: assert property (POWERDOWN_GROUP_A[*5] |-> PATH_RESET_A && !TERM_50_A)
        else $error("group a not held");
    chk_pd_b_hiz: assert property (POWERDOWN_GROUP_B[*5] |-> !TERM_50_B)
        else $error("group b not high-z");
    chk_standby_on: assert property ((POWERDOWN_GROUP_A && POWERDOWN_GROUP_B)[*5] |-> STANDBY)
        else $error("no standby");
    chk_standby_off: assert property (!POWERDOWN_GROUP_A[*5] |-> !STANDBY)
        else $error("false standby");
    chk_det_off: assert property (
        (DETECT_CONFIG_PIN == 2'h0 && !POWERDOWN_GROUP_A && !POWERDOWN_GROUP_B)[*5] |-> TERM_50_A && TERM_50_B)
        else $error("buffer not 50 ohm");
    chk_cross_a: assert property ($stable(MUX_SELECT_GROUP_A)[*5] |-> CROSS_A == MUX_SELECT_GROUP_A)
        else $error("cross a wrong");
    chk_pulse_gap: assert property (DETECT_PULSE_A |=> !DETECT_PULSE_A[*8])
        else $error("attempts too close");
    chk_done_stays: assert property ($fell(LOAD_DONE_N) |=> !LOAD_DONE_N[*8])
        else $error("done released");
    cover property ($rose(TERM_50_A));
    cover property (STANDBY);
    cover property ($fell(LOAD_DONE_N));
endmodule // rdc_ctrl_sva
bind rdc_ctrl rdc_ctrl_sva #(.POLL_CYC(POLL_CYC)) u_rdc_ctrl_sva (
    .MCLK(MCLK), .RST(RST), .POWERDOWN_GROUP_A(POWERDOWN_GROUP_A), .POWERDOWN_GROUP_B(POWERDOWN_GROUP_B),
    .DETECT_CONFIG_PIN(DETECT_CONFIG_PIN), .MUX_SELECT_GROUP_A(MUX_SELECT_GROUP_A), .CROSS_A(CROSS_A),
    .TERM_50_A(TERM_50_A), .TERM_50_B(TERM_50_B), .PATH_RESET_A(PATH_RESET_A),
    .DETECT_PULSE_A(DETECT_PULSE_A), .STANDBY(STANDBY), .LOAD_DONE_N(LOAD_DONE_N)
);

// >>> verif/rdc_far_end.sv
`timescale 1ns/1ps
// ********
// far end termination model
// ********
module rdc_far_end (
    input wire mclk,
    input wire rst,
    input wire detect_pulse,
    input wire present,
    input wire slow,
    output wire far_term
);
    logic [1:0] seen_ff;
    always @(posedge mclk)
        if (rst || !present)
            seen_ff <= 2'h0;
        else if (detect_pulse && seen_ff != 2'h3)
            seen_ff <= seen_ff + 2'h1;
    // seen after one attempt, or two when slow
    assign far_term = present && seen_ff > {1'b0, slow};
endmodule // rdc_far_end

// >>> verif/testbench.sv
`timescale 1ns/1ps
`include "rdc_map.vh"
module testbench;
    // ********
    // harness
    // ********
    logic mclk, rst, pd_a, pd_b, ld_n, psel, pen, pwr, pres_a, pres_b, perr_s;
    logic [1:0] dcp, mode;
    logic [13:0] pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire [3:0] idx_a, idx_b;
    wire [1:0] fl_a, fl_b;
    wire x_a, x_b, t50_a, t50_b, pr_a, pr_b, dp_a, dp_b, stby, done_n, prdy, perr, ft_a, ft_b, ld_act;
    wire [31:0] prdata;
    wire [3:0] ev = {dp_b, t50_b, t50_a, dp_a};
    logic [13:0] rin [4] = '{14'h3c32, 14'h03cd, 14'h1a5b, 14'h25a4};
    logic [13:0] rexp [4] = '{14'h3c32, 14'h03cd, 14'h1a5b, 14'h25a4};
    int err_total = 0;
    int total_checks = 0;
    int i;
    rdc_ctrl #(.POLL_CYC(20)) u_rdc_ctrl (
        .MCLK(mclk), .RST(rst), .BOOST_HIGH_DIGIT_GROUP_A(pin[13:12]), .BOOST_LOW_DIGIT_GROUP_A(pin[11:10]),
        .BOOST_HIGH_DIGIT_GROUP_B(pin[9:8]), .BOOST_LOW_DIGIT_GROUP_B(pin[7:6]), .FLAT_LEVEL_GROUP_A(pin[5:4]),
        .FLAT_LEVEL_GROUP_B(pin[3:2]), .POWERDOWN_GROUP_A(pd_a), .POWERDOWN_GROUP_B(pd_b),
        .DETECT_CONFIG_PIN(dcp), .MUX_SELECT_GROUP_A(pin[1]), .MUX_SELECT_GROUP_B(pin[0]), .MODE_PIN(mode),
        .LOAD_START_N(ld_n), .FAR_TERM_A(ft_a), .FAR_TERM_B(ft_b), .BOOST_INDEX_A(idx_a), .BOOST_INDEX_B(idx_b),
        .FLAT_A(fl_a), .FLAT_B(fl_b), .CROSS_A(x_a), .CROSS_B(x_b), .TERM_50_A(t50_a), .TERM_50_B(t50_b),
        .PATH_RESET_A(pr_a), .PATH_RESET_B(pr_b), .DETECT_PULSE_A(dp_a), .DETECT_PULSE_B(dp_b), .STANDBY(stby),
        .LOAD_DONE_N(done_n), .LOAD_ACTIVE(ld_act), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr)
    );
    rdc_far_end u_rdc_far_end_a (.mclk(mclk), .rst(rst), .detect_pulse(dp_a), .present(pres_a), .slow(1'b0),
        .far_term(ft_a));
    rdc_far_end u_rdc_far_end_b (.mclk(mclk), .rst(rst), .detect_pulse(dp_b), .present(pres_b), .slow(1'b1),
        .far_term(ft_b));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wait_for(input int s, input string nm);
        int k;
        for (k = 0; k < 200; k++)
        begin
            @(posedge mclk);
            if (ev[s] === 1'b1)
                break;
        end
        chk(nm, ev[s], 1'b1);
        if (k == 200)
            tally_and_finish();
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge mclk);
            if (prdy === 1'b1)
                break;
        end
        rd = prdata;
        perr_s = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k == 50)
        begin
            chk("ready", prdy, 1'b1);
            tally_and_finish();
        end
        @(posedge mclk);
    endtask
    // ********
    // sequence
    // ********
    initial
    begin
        {rst, pd_a, pd_b, ld_n, psel, pen, pwr, pres_a, pres_b} = 9'h120;
        {dcp, mode, pin, paddr, pwdata} = '0;
        repeat (3) @(posedge mclk);
        chk("reset", {t50_a, pr_a, done_n, fl_a, idx_a}, 9'h0f0);
        rst <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            pin <= rin[i];
            cyc(5);
            chk("pins", {idx_a, idx_b, fl_a, fl_b, x_a, x_b}, rexp[i]);
        end
        chk("buffer", {t50_a, t50_b}, 2'h3);
        dcp <= 2'h3;
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        wait_for(0, "attempt");
        chk("hiz", {t50_a, t50_b}, 2'h0);
        wait_for(0, "retry");
        {pres_a, pres_b} <= 2'h3;
        wait_for(1, "link a");
        wait_for(2, "link b");
        pd_a <= 1'b1;
        cyc(5);
        chk("pd a", {t50_a, pr_a, t50_b, pr_b, stby}, 5'h0c);
        pd_b <= 1'b1;
        cyc(5);
        chk("standby", {t50_a, t50_b, stby}, 3'h1);
        pd_a <= 1'b0;
        wait_for(0, "restart a");
        wait_for(1, "relink a");
        chk("pd b", {t50_b, pr_b, stby}, 3'h2);
        pd_b <= 1'b0;
        wait_for(2, "relink b");
        pin <= pin ^ 14'h2;
        wait_for(0, "mux restart");
        mode <= 2'h2;
        cyc(5);
        apb(1'b1, `RDC_OFF_BOOST, 32'h5a);
        cyc(2);
        chk("reg boost", {idx_a, idx_b}, 8'ha5);
        apb(1'b0, `RDC_OFF_BOOST, 32'h0);
        chk("boost read", rd, 32'h5a);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {perr_s, rd}, 33'h100000000);
        apb(1'b1, `RDC_OFF_CTRL, 32'h1);
        wait_for(0, "reg restart");
        apb(1'b1, `RDC_OFF_CTRL, 32'h2);
        wait_for(3, "reg restart b");
        mode <= 2'h1;
        ld_n <= 1'b0;
        cyc(5);
        apb(1'b0, `RDC_OFF_STAT, 32'h0);
        chk("stat mode", {done_n, ld_act, rd[5:4]}, 4'hd);
        apb(1'b1, `RDC_OFF_CTRL, 32'h4);
        cyc(2);
        chk("load done", {done_n, ld_act}, 2'h0);
        ld_n <= 1'b1;
        cyc(5);
        ld_n <= 1'b0;
        cyc(5);
        chk("load once", {done_n, ld_act}, 2'h0);
        tally_and_finish();
    end
endmodule // testbench
